//--- dcs_pkg.sv
// Shared constants and types for the DDS core with system clock selection.
package dcs_pkg;

    // ==========================================================
    // Widths
    localparam int unsigned PHASE_W = 32;
    localparam int unsigned DAC_W   = 14;
    localparam int unsigned CW2_W   = 24;
    localparam int unsigned ADDR_W  = 8;
    localparam int unsigned MULT_W  = 5;
    localparam int unsigned LOCK_W  = 15;

    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] OFF_CW1     = 8'h00;
    localparam logic [7:0] OFF_CW2     = 8'h04;
    localparam logic [7:0] OFF_FTW     = 8'h08;
    localparam logic [7:0] OFF_UPDATE  = 8'h0C;
    localparam logic [7:0] OFF_STATUS  = 8'h10;
    localparam logic [7:0] OFF_PHASE   = 8'h14;
    localparam logic [7:0] OFF_ACT_CW1 = 8'h18;
    localparam logic [7:0] OFF_ACT_CW2 = 8'h1C;
    localparam logic [7:0] OFF_ACT_FTW = 8'h20;

    // ==========================================================
    // Field positions
    localparam int unsigned CW1_CLK_PD_BIT  = 4;
    localparam int unsigned CW1_CLR_PH_BIT  = 10;
    localparam int unsigned CW2_MULT_LSB    = 3;
    localparam int unsigned CW2_MULT_MSB    = 7;
    localparam int unsigned CW2_XTAL_BIT    = 9;
    localparam int unsigned UPDATE_BIT      = 0;
    localparam int unsigned ST_CLR_PH_BIT   = 0;
    localparam int unsigned ST_CLK_OFF_BIT  = 1;
    localparam int unsigned ST_OSC_ON_BIT   = 2;
    localparam int unsigned ST_PLL_ON_BIT   = 3;
    localparam int unsigned ST_SETTLE_BIT   = 4;
    localparam int unsigned ST_PLL_RDY_BIT  = 5;

    // ==========================================================
    // Reset values and encodings
    localparam logic [31:0] CW1_BUF_RST = 32'h0000_0000;
    localparam logic [31:0] CW1_ACT_RST = 32'h0000_0400;
    localparam logic [23:0] CW2_RST     = 24'h00_0000;
    localparam logic [31:0] FTW_RST     = 32'h0000_0000;
    localparam logic [31:0] ZERO_WORD   = 32'h0000_0000;
    localparam logic [4:0]  MULT_MIN    = 5'h04;
    localparam logic [4:0]  MULT_MAX    = 5'h14;
    localparam logic [31:0] QUARTER_TURN = 32'h4000_0000;
    localparam logic [13:0] DAC_MID     = 14'h2000;

    // ==========================================================
    // Timing: PLL lock allowance, 1 ms at a 20 MHz clock
    localparam int unsigned CLK_MHZ        = 20;
    localparam int unsigned PLL_LOCK_US    = 1000;
    localparam int unsigned PLL_LOCK_CYCLES = PLL_LOCK_US * CLK_MHZ;

    typedef enum logic [2:0] {
        PLL_OFF    = 3'b001,
        PLL_SETTLE = 3'b010,
        PLL_READY  = 3'b100
    } dcs_pll_state_t;

endpackage

//--- dcs_phase_if.sv
// Phase and amplitude link between the accumulator and the cosine converter.
`timescale 1ns/10ps
`default_nettype none
interface dcs_phase_if;
    logic [dcs_pkg::PHASE_W-1:0] phase;
    logic [dcs_pkg::DAC_W-1:0]   amplitude;
    modport src  (output phase, input amplitude);
    modport conv (input phase, output amplitude);
endinterface
`default_nettype wire

//--- dcs_cosine.sv
// Phase to amplitude converter with a registered 14-bit output.
`timescale 1ns/10ps
`default_nettype none
module dcs_cosine (
    input  wire logic i_clk,
    input  wire logic i_rst,
    dcs_phase_if.conv bus
);
    import dcs_pkg::*;

    // A parabolic half wave stands in for a table: no memory, one multiplier,
    // and the peak error stays near three percent of full scale.
    logic [31:0] cos_phase;
    logic        neg_half;
    logic [12:0] frac;
    logic [12:0] frac_rest;
    logic [25:0] prod;
    logic [13:0] mag;
    logic [13:0] next_amplitude;
    logic [13:0] amplitude;

    assign cos_phase = bus.phase + QUARTER_TURN;
    assign neg_half  = cos_phase[31];
    assign frac      = cos_phase[30:18];
    assign frac_rest = 13'h1FFF - frac;
    assign prod      = frac * frac_rest;
    assign mag       = {1'b0, prod[23:11]};

    assign next_amplitude = neg_half ? DAC_MID - mag : DAC_MID + mag;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            amplitude <= DAC_MID;
        end else begin
            amplitude <= next_amplitude;
        end
    end

    assign bus.amplitude = amplitude;

endmodule
`default_nettype wire

//--- dcs_core.sv
// DDS core with phase accumulator, register transfer and system clock selection.
//
// What this block does
// - Output frequency is tuning word times clock over two to the 32.
// - Accumulator phase becomes a cosine amplitude, passed as 14 bits.
// - A zero tuning word freezes the phase; it does not reset it.
// - While clear-phase is active the accumulator output is forced to zero.
// - After reset active clear-phase is 1, buffered copy 0, until first transfer.
// - A transfer strobe copies buffered control words into the active ones.
// - Multiplier field bits 7 to 3, values 4 to 20, set PLL ratio.
// - Multiplier outside 4 to 20 bypasses the PLL and powers it down.
// - Select pin low disables oscillator and buffer, uses external reference.
// - Clock power-down bit 4 of word one stops the synthesis clock.
// - The crystal oscillator stays powered while the synthesis clock is stopped.
// - Bit 9 of word two enables the buffered oscillator output.
// - Multiplier handling does not depend on the clock power-down bit.
//
// Added by the designer: register access over APB and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module dcs_core #(
    parameter int unsigned P_LOCK_CYCLES = dcs_pkg::PLL_LOCK_CYCLES
) (
    input  wire logic                        I_MCLK,
    input  wire logic                        I_RST,
    input  wire logic                        I_PSEL,
    input  wire logic                        I_PENABLE,
    input  wire logic                        I_PWRITE,
    input  wire logic [dcs_pkg::ADDR_W-1:0]  I_PADDR,
    input  wire logic [31:0]                 I_PWDATA,
    input  wire logic [3:0]                  I_PSTRB,
    output logic      [31:0]                 O_PRDATA,
    output logic                             O_PREADY,
    output logic                             O_PSLVERR,
    input  wire logic                        I_OSCILLATOR_SELECT_PIN,
    output logic      [dcs_pkg::DAC_W-1:0]   O_DAC_DATA,
    output logic                             O_OSC_EN,
    output logic                             O_XTAL_OUT_EN,
    output logic                             O_REFERENCE_CLOCK_INPUT_SEL,
    output logic                             O_PLL_EN,
    output logic      [dcs_pkg::MULT_W-1:0]  O_PLL_MULT,
    output logic                             O_SYNTHESIS_CLOCK_EN
);
    import dcs_pkg::*;

    localparam logic [LOCK_W-1:0] LOCK_LAST = LOCK_W'(P_LOCK_CYCLES - 1);

    // ==========================================================
    // Helpers

    // Byte-lane merge used by every writable register.
    function automatic logic [31:0] merge_bytes(
        input logic [31:0] old_val,
        input logic [31:0] new_val,
        input logic [3:0]  lanes
    );
        logic [31:0] res;
        res = old_val;
        for (int i = 0; i < 4; i++) begin
            if (lanes[i]) begin
                res[8*i +: 8] = new_val[8*i +: 8];
            end
        end
        return res;
    endfunction

    // ==========================================================
    // Declarations

    logic [31:0]       control_word_one_buf;
    logic [CW2_W-1:0]  control_word_two_buf;
    logic [31:0]       frequency_tuning_word_buf;
    logic [31:0]       control_word_one;
    logic [CW2_W-1:0]  control_word_two;
    logic [31:0]       frequency_tuning_word;
    logic [31:0]       phase_acc;
    logic [31:0]       next_phase_acc;
    logic              osc_meta;
    logic              osc_sel;
    dcs_pll_state_t    pll_state;
    dcs_pll_state_t    next_pll_state;
    logic [LOCK_W-1:0] lock_cnt;
    logic [LOCK_W-1:0] next_lock_cnt;
    logic [MULT_W-1:0] mult_seen;
    logic [31:0]       rdata;
    logic              rerr;
    logic [31:0]       next_rdata;
    logic              next_rerr;
    logic [31:0]       cw2_merged;

    dcs_phase_if phase_link ();

    // ==========================================================
    // Bus decode

    wire setup_phase  = I_PSEL & ~I_PENABLE;
    wire access_phase = I_PSEL & I_PENABLE;
    wire wr_access    = access_phase & I_PWRITE;
    wire sel_cw1      = I_PADDR == OFF_CW1;
    wire sel_cw2      = I_PADDR == OFF_CW2;
    wire sel_ftw      = I_PADDR == OFF_FTW;
    wire sel_update   = I_PADDR == OFF_UPDATE;
    wire sel_status   = I_PADDR == OFF_STATUS;
    wire sel_phase    = I_PADDR == OFF_PHASE;
    wire sel_act_cw1  = I_PADDR == OFF_ACT_CW1;
    wire sel_act_cw2  = I_PADDR == OFF_ACT_CW2;
    wire sel_act_ftw  = I_PADDR == OFF_ACT_FTW;
    wire sel_rw       = sel_cw1 | sel_cw2 | sel_ftw | sel_update;
    wire sel_ro       = sel_status | sel_phase | sel_act_cw1 | sel_act_cw2 | sel_act_ftw;

    // The strobe fires only when the low byte lane carries a one in bit zero.
    wire update_strobe = wr_access & sel_update & I_PSTRB[0] & I_PWDATA[UPDATE_BIT];

    assign cw2_merged = merge_bytes({8'h00, control_word_two_buf}, I_PWDATA, I_PSTRB);

    // ==========================================================
    // Active control decode

    wire clr_phase = control_word_one[CW1_CLR_PH_BIT];
    wire clk_off   = control_word_one[CW1_CLK_PD_BIT];
    wire xtal_req  = control_word_two[CW2_XTAL_BIT];
    wire [MULT_W-1:0] mult = control_word_two[CW2_MULT_MSB:CW2_MULT_LSB];
    // The range test looks only at the multiplier field, never at clk_off.
    wire pll_on = (mult >= MULT_MIN) && (mult <= MULT_MAX);
    wire osc_on = osc_sel;

    // ==========================================================
    // Buffered control memory, written over the bus

    always_ff @(posedge I_MCLK or posedge I_RST) begin
        if (I_RST) begin
            control_word_one_buf      <= CW1_BUF_RST;
            control_word_two_buf      <= CW2_RST;
            frequency_tuning_word_buf <= FTW_RST;
        end else if (wr_access) begin
            if (sel_cw1) begin
                control_word_one_buf <= merge_bytes(control_word_one_buf, I_PWDATA, I_PSTRB);
            end
            if (sel_cw2) begin
                control_word_two_buf <= cw2_merged[CW2_W-1:0];
            end
            if (sel_ftw) begin
                frequency_tuning_word_buf <= merge_bytes(frequency_tuning_word_buf, I_PWDATA, I_PSTRB);
            end
        end
    end

    // ==========================================================
    // Active control registers, loaded by the transfer strobe

    // Clear-phase comes up set in the active word while the buffered word is
    // clear, so the phase stays at zero until software issues a transfer.
    always_ff @(posedge I_MCLK or posedge I_RST) begin
        if (I_RST) begin
            control_word_one      <= CW1_ACT_RST;
            control_word_two      <= CW2_RST;
            frequency_tuning_word <= FTW_RST;
        end else if (update_strobe) begin
            control_word_one      <= control_word_one_buf;
            control_word_two      <= control_word_two_buf;
            frequency_tuning_word <= frequency_tuning_word_buf;
        end
    end

    // ==========================================================
    // Phase accumulator

    // A zero tuning word simply adds nothing, so the phase holds where it is.
    always_comb begin
        if (clk_off) begin
            next_phase_acc = phase_acc;
        end else if (clr_phase) begin
            next_phase_acc = ZERO_WORD;
        end else begin
            next_phase_acc = phase_acc + frequency_tuning_word;
        end
    end

    always_ff @(posedge I_MCLK or posedge I_RST) begin
        if (I_RST) begin
            phase_acc <= ZERO_WORD;
        end else begin
            phase_acc <= next_phase_acc;
        end
    end

    // The output is forced even while the clock is stopped with a stale phase.
    assign phase_link.phase = clr_phase ? ZERO_WORD : phase_acc;

    // ==========================================================
    // Cosine conversion

    dcs_cosine u_cosine (
        .i_clk (I_MCLK),
        .i_rst (I_RST),
        .bus   (phase_link.conv)
    );

    assign O_DAC_DATA = phase_link.amplitude;

    // ==========================================================
    // Oscillator select pin synchroniser

    always_ff @(posedge I_MCLK or posedge I_RST) begin
        if (I_RST) begin
            osc_meta <= 1'b0;
            osc_sel  <= 1'b0;
        end else begin
            osc_meta <= I_OSCILLATOR_SELECT_PIN;
            osc_sel  <= osc_meta;
        end
    end

    // ==========================================================
    // PLL lock tracking

    // Software owns the lock wait; this tracker only reports whether the lock
    // allowance has run out since the last multiplier change, so a driver can poll it.
    always_comb begin
        next_pll_state = pll_state;
        next_lock_cnt  = lock_cnt;
        case (pll_state)
            PLL_OFF: begin
                next_lock_cnt = '0;
                if (pll_on) begin
                    next_pll_state = PLL_SETTLE;
                end
            end
            PLL_SETTLE: begin
                if (!pll_on) begin
                    next_pll_state = PLL_OFF;
                end else if (mult != mult_seen) begin
                    next_lock_cnt = '0;
                end else if (lock_cnt == LOCK_LAST) begin
                    next_pll_state = PLL_READY;
                end else begin
                    next_lock_cnt = lock_cnt + 1'b1;
                end
            end
            PLL_READY: begin
                next_lock_cnt = '0;
                if (!pll_on) begin
                    next_pll_state = PLL_OFF;
                end else if (mult != mult_seen) begin
                    next_pll_state = PLL_SETTLE;
                end
            end
            default: begin
                next_pll_state = PLL_OFF;
                next_lock_cnt  = '0;
            end
        endcase
    end

    always_ff @(posedge I_MCLK or posedge I_RST) begin
        if (I_RST) begin
            pll_state <= PLL_OFF;
            lock_cnt  <= '0;
            mult_seen <= '0;
        end else begin
            pll_state <= next_pll_state;
            lock_cnt  <= next_lock_cnt;
            mult_seen <= mult;
        end
    end

    // ==========================================================
    // Clock selection outputs

    // The oscillator enable follows the pin alone: stopping the synthesis
    // clock leaves the crystal running, which saves a slow restart.
    always_ff @(posedge I_MCLK or posedge I_RST) begin
        if (I_RST) begin
            O_OSC_EN                    <= 1'b0;
            O_XTAL_OUT_EN               <= 1'b0;
            O_REFERENCE_CLOCK_INPUT_SEL <= 1'b1;
            O_PLL_EN                    <= 1'b0;
            O_PLL_MULT                  <= '0;
            O_SYNTHESIS_CLOCK_EN        <= 1'b0;
        end else begin
            O_OSC_EN                    <= osc_on;
            O_XTAL_OUT_EN               <= osc_on & xtal_req;
            O_REFERENCE_CLOCK_INPUT_SEL <= ~osc_on;
            O_PLL_EN                    <= pll_on;
            O_PLL_MULT                  <= pll_on ? mult : '0;
            O_SYNTHESIS_CLOCK_EN        <= ~clk_off;
        end
    end

    // ==========================================================
    // Read path

    wire [31:0] status_word = {26'h000_0000,
                               pll_state == PLL_READY,
                               pll_state == PLL_SETTLE,
                               pll_on,
                               osc_on,
                               clk_off,
                               clr_phase};

    // Read data is sampled in the setup cycle so that it leaves a flop.
    always_comb begin
        next_rerr = 1'b0;
        if (sel_cw1) begin
            next_rdata = control_word_one_buf;
        end else if (sel_cw2) begin
            next_rdata = {8'h00, control_word_two_buf};
        end else if (sel_ftw) begin
            next_rdata = frequency_tuning_word_buf;
        end else if (sel_status) begin
            next_rdata = status_word;
        end else if (sel_phase) begin
            next_rdata = phase_link.phase;
        end else if (sel_act_cw1) begin
            next_rdata = control_word_one;
        end else if (sel_act_cw2) begin
            next_rdata = {8'h00, control_word_two};
        end else if (sel_act_ftw) begin
            next_rdata = frequency_tuning_word;
        end else begin
            next_rdata = ZERO_WORD;
            next_rerr  = ~sel_rw;
        end
        if (I_PWRITE && sel_ro) begin
            next_rerr = 1'b1;
        end
    end

    always_ff @(posedge I_MCLK or posedge I_RST) begin
        if (I_RST) begin
            rdata <= ZERO_WORD;
            rerr  <= 1'b0;
        end else if (setup_phase) begin
            rdata <= I_PWRITE ? ZERO_WORD : next_rdata;
            rerr  <= next_rerr;
        end
    end

    assign O_PRDATA  = rdata;
    assign O_PREADY  = 1'b1;
    assign O_PSLVERR = rerr & access_phase;

endmodule
`default_nettype wire

//--- dcs_core_asserts.sv
// Checker for clock selection, transfer timing and startup phase of the core.
`timescale 1ns/10ps
`default_nettype none
module dcs_core_chk (
    input wire logic                        I_MCLK,
    input wire logic                        I_RST,
    input wire logic                        I_PSEL,
    input wire logic                        I_PENABLE,
    input wire logic                        I_PWRITE,
    input wire logic [dcs_pkg::ADDR_W-1:0]  I_PADDR,
    input wire logic [31:0]                 I_PWDATA,
    input wire logic [3:0]                  I_PSTRB,
    input wire logic                        I_OSCILLATOR_SELECT_PIN,
    input wire logic [dcs_pkg::DAC_W-1:0]   O_DAC_DATA,
    input wire logic                        O_OSC_EN,
    input wire logic                        O_XTAL_OUT_EN,
    input wire logic                        O_REFERENCE_CLOCK_INPUT_SEL,
    input wire logic                        O_PLL_EN,
    input wire logic [dcs_pkg::MULT_W-1:0]  O_PLL_MULT,
    input wire logic                        O_SYNTHESIS_CLOCK_EN
);
    import dcs_pkg::*;
    default clocking cb @(posedge I_MCLK);
    endclocking
    default disable iff (I_RST);
    // ====================
    // Shadows of the buffered words, so each transfer can be predicted.
    logic       pd_sh;
    logic [4:0] mu_sh;
    logic [1:0] age;
    logic       seen;
    wire        wr_ok  = I_PSEL && I_PENABLE && I_PWRITE && I_PSTRB[0];
    wire        strobe = wr_ok && I_PADDR == OFF_UPDATE && I_PWDATA[UPDATE_BIT];
    wire        mu_ok  = mu_sh >= MULT_MIN && mu_sh <= MULT_MAX;
    always_ff @(posedge I_MCLK or posedge I_RST) begin
        if (I_RST) begin
            pd_sh <= 1'b0;
            mu_sh <= 5'h00;
            age   <= 2'h0;
            seen  <= 1'b0;
        end else begin
            if (age != 2'h3) age <= age + 2'h1;
            if (strobe) seen <= 1'b1;
            if (wr_ok && I_PADDR == OFF_CW1) pd_sh <= I_PWDATA[CW1_CLK_PD_BIT];
            if (wr_ok && I_PADDR == OFF_CW2) mu_sh <= I_PWDATA[CW2_MULT_MSB:CW2_MULT_LSB];
        end
    end
    // ====================
    // Properties.
    sequence s_strobe;
        strobe;
    endsequence
    sequence s_pin_hi;
        (age != 2'h0 && I_OSCILLATOR_SELECT_PIN) [*4];
    endsequence
    sequence s_pin_lo;
        !I_OSCILLATOR_SELECT_PIN [*4];
    endsequence
    property p_pin_on;
        s_pin_hi |-> O_OSC_EN && !O_REFERENCE_CLOCK_INPUT_SEL;
    endproperty
    property p_pin_off;
        s_pin_lo |-> !O_OSC_EN && !O_XTAL_OUT_EN && O_REFERENCE_CLOCK_INPUT_SEL;
    endproperty
    property p_xtal_osc;
        O_XTAL_OUT_EN |-> O_OSC_EN;
    endproperty
    property p_pll_range;
        O_PLL_EN |-> O_PLL_MULT inside {[MULT_MIN:MULT_MAX]};
    endproperty
    property p_pll_bypass;
        !O_PLL_EN |-> O_PLL_MULT == 5'h00;
    endproperty
    property p_pll_follow;
        s_strobe |-> ##2 O_PLL_EN == mu_ok && O_PLL_MULT == (mu_ok ? mu_sh : 5'h00);
    endproperty
    property p_clk_gate;
        s_strobe |-> ##2 O_SYNTHESIS_CLOCK_EN == !pd_sh;
    endproperty
    property p_no_spont;
        $changed(O_PLL_MULT) && age == 2'h3 |-> $past(strobe, 2);
    endproperty
    property p_dac_cleared;
        age == 2'h3 && !seen |-> O_DAC_DATA == 14'h3FFE;
    endproperty
    a_pin_on: assert property (p_pin_on) else $error("oscillator not on");
    a_pin_off: assert property (p_pin_off) else $error("oscillator not off");
    a_xtal_osc: assert property (p_xtal_osc) else $error("buffer on without oscillator");
    a_pll_range: assert property (p_pll_range) else $error("pll ratio out of range");
    a_pll_bypass: assert property (p_pll_bypass) else $error("bypass with ratio");
    a_pll_follow: assert property (p_pll_follow) else $error("pll not per field");
    a_clk_gate: assert property (p_clk_gate) else $error("clock gate wrong");
    a_no_spont: assert property (p_no_spont) else $error("ratio moved without transfer");
    a_dac_cleared: assert property (p_dac_cleared) else $error("phase not clear");
endmodule
bind dcs_core dcs_core_chk u_chk (.*);
`default_nettype wire

//--- dcs_ref_model.sv
// Far-side model: reference source that drives the select pin and judges lock.
`timescale 1ns/10ps
`default_nettype none
module dcs_ref_model #(
    parameter int REF_MHZ = 20,
    parameter int LOCK    = 8
) (
    input  wire logic       i_clk,
    input  wire logic       i_want_osc,
    input  wire logic [4:0] i_mult,
    input  wire logic       i_pll_en,
    output logic            o_pin,
    output logic            o_over,
    output logic            o_locked
);
    logic [4:0] last = 5'h00;
    int         cnt  = 0;
    initial o_pin = 1'b0;
    // Lock time restarts on every ratio change; the user waits it out.
    always @(posedge i_clk) begin
        o_pin <= i_want_osc;
        last  <= i_mult;
        if (i_mult != last) cnt <= 0;
        else if (cnt < LOCK) cnt <= cnt + 1;
    end
    assign o_locked = !i_pll_en || cnt >= LOCK;
    assign o_over   = i_pll_en && REF_MHZ * int'(i_mult) > 400;
endmodule
`default_nettype wire

//--- dcs_core_tb_top.sv
// Self-checking bench for the DDS core with clock selection.
`timescale 1ns/10ps
`default_nettype none
module dcs_core_tb_top;
    import dcs_pkg::*;
    logic        clk, rst, psel, pen, pwr, want, er;
    logic [7:0]  paddr;
    logic [31:0] pwdata, rd;
    logic [3:0]  pstrb;
    wire  [31:0] prdata;
    wire  [13:0] dac;
    wire  [4:0]  mult;
    wire         pready, pslverr, osc_en, xo_en, ref_sel, pll_en, sclk_en, pin, over, locked;
    int          n_errors = 0;
    int          check_count = 0;
    logic [4:0]  tbl [7] = '{5'h00, 5'h03, 5'h04, 5'h0D, 5'h14, 5'h15, 5'h1F};
    dcs_core #(.P_LOCK_CYCLES(8)) u_dut (.I_MCLK(clk), .I_RST(rst), .I_PSEL(psel),
        .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .I_PSTRB(pstrb),
        .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .I_OSCILLATOR_SELECT_PIN(pin),
        .O_DAC_DATA(dac), .O_OSC_EN(osc_en), .O_XTAL_OUT_EN(xo_en),
        .O_REFERENCE_CLOCK_INPUT_SEL(ref_sel), .O_PLL_EN(pll_en), .O_PLL_MULT(mult),
        .O_SYNTHESIS_CLOCK_EN(sclk_en));
    dcs_ref_model #(.REF_MHZ(20), .LOCK(8)) u_ref (.i_clk(clk), .i_want_osc(want),
        .i_mult(mult), .i_pll_en(pll_en), .o_pin(pin), .o_over(over), .o_locked(locked));
    // ====================
    // Tasks.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t %s: got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel   <= 1'b1;
        pen    <= 1'b0;
        pwr    <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) n_errors++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        pen  <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
        apb(1'b0, a, ZERO_WORD);
        chk(rd, exp, what);
    endtask
    task automatic xfer;
        apb(1'b1, OFF_UPDATE, 32'h0000_0001);
    endtask
    // Model of the clock selection: ratio, gate, oscillator and buffer.
    task automatic chk_clk(input logic [4:0] m, input logic pd, input logic x, input logic p);
        logic on;
        on = m >= MULT_MIN && m <= MULT_MAX;
        chk(32'({pll_en, mult, sclk_en, osc_en, xo_en, ref_sel}),
            32'({on, on ? m : 5'h00, !pd, p, p & x, !p}), "clock outputs");
    endtask
    task automatic close_out;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        #1000000;
        n_errors++;
        close_out();
    end
    // ====================
    // Tests.
    initial begin
        logic [31:0] f, fp, p1;
        logic [4:0]  m, mp;
        logic        pd, x, p, pdp, xp;
        {rst, want} = 2'b11;
        {psel, pen, pwr, paddr, pwdata} = '0;
        pstrb = 4'hF;
        void'($urandom(32'hf5fb001c));
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rdchk(OFF_ACT_CW1, CW1_ACT_RST, "active word one");
        rdchk(OFF_CW1, CW1_BUF_RST, "buffered word one");
        rdchk(OFF_PHASE, ZERO_WORD, "phase at startup");
        chk(32'(dac), 32'h0000_3FFE, "amplitude at zero phase");
        $display("test startup done");
        fp = FTW_RST;
        for (int i = 0; i < 4; i++) begin
            f = (i == 0) ? 32'hFFFF_FFFF : $urandom();
            apb(1'b1, OFF_FTW, f);
            rdchk(OFF_ACT_FTW, fp, "tuning word before transfer");
            xfer();
            rdchk(OFF_ACT_FTW, f, "tuning word after transfer");
            apb(1'b0, OFF_PHASE, ZERO_WORD);
            p1 = rd;
            rdchk(OFF_PHASE, p1 + f + f + f, "phase step");
            fp = f;
        end
        $display("test accumulate done");
        apb(1'b1, OFF_FTW, FTW_RST);
        xfer();
        apb(1'b0, OFF_PHASE, ZERO_WORD);
        p1 = rd;
        repeat (5) @(posedge clk);
        rdchk(OFF_PHASE, p1, "frozen phase");
        chk(32'(p1 == ZERO_WORD), 32'h0000_0000, "phase returned to zero");
        $display("test freeze done");
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, OFF_CW1, 32'(1) << CW1_CLR_PH_BIT);
            xfer();
            rdchk(OFF_PHASE, ZERO_WORD, "cleared phase");
            apb(1'b1, OFF_CW1, CW1_BUF_RST);
            apb(1'b1, OFF_FTW, QUARTER_TURN);
            xfer();
            repeat ($urandom_range(3)) @(posedge clk);
            apb(1'b1, OFF_FTW, FTW_RST);
            xfer();
            apb(1'b0, OFF_PHASE, ZERO_WORD);
            p1 = rd;
            repeat (3) @(posedge clk);
            if (p1[31:30] == 2'b10) chk(32'(dac < 14'h0008), 32'h0000_0001, "half turn");
            else chk(32'(dac), p1[30] ? 32'(DAC_MID) : 32'h0000_3FFE, "amplitude");
        end
        $display("test amplitude done");
        {mp, pdp, xp} = '0;
        foreach (tbl[j]) begin
            m = tbl[j];
            pd = (j == 0) | 1'($urandom_range(1));
            x = 1'($urandom_range(1));
            p = (j == 0) | 1'($urandom_range(1));
            want <= p;
            apb(1'b1, OFF_CW1, 32'(pd) << CW1_CLK_PD_BIT);
            apb(1'b1, OFF_CW2, (32'(x) << CW2_XTAL_BIT) | (32'(m) << CW2_MULT_LSB));
            chk_clk(mp, pdp, xp, p);
            xfer();
            repeat (3) @(posedge clk);
            chk_clk(m, pd, x, p);
            chk(32'(over), 32'h0000_0000, "pll above limit");
            for (int w = 0; w < 20 && !locked; w++) @(posedge clk);
            chk(32'(locked), 32'h0000_0001, "pll lock wait");
            {mp, pdp, xp} = {m, pd, x};
        end
        $display("test clock select done");
        apb(1'b0, 8'h40, ZERO_WORD);
        chk({rd[30:0], er}, 32'h0000_0001, "unmapped read");
        $display("test unmapped done");
        close_out();
    end
endmodule
`default_nettype wire
